// [core/mqp_defines.vh]
// Constants for the mouse quadrature poll cycle block.
// Assumes a 125 MHz clock and a 32-bit AXI4-Lite bus.
//
// Function
// - Reset clears all state, loads defaults, then starts sampling.
// - Each cycle starts with a snapshot of the input port.
// - A button change copies the new button states into status.
// - Per axis, phase pair versus stored copy gives step +1, -1 or null.
// - Accumulators span plus or minus 32735; steps add or subtract, null holds.
// - An enabled event packs both accumulators behind a header, then clears them.
// - Without an event, a set command flag decodes and runs the command.
// - Output toward the host happens only on timer expiry.
// - Expiry with output still full signals again and restarts the timer.
// - Expiry with output taken and bytes left loads the next byte, signals.
// - Timed transfers on and expiry: pack accumulators, start sending, clear them.
// - Status bits 4 to 6 hold the buttons, one meaning released.
// - Loading the output register sets full flag bit 0 and signals.
// - The host line toggles on each signal.
`ifndef MQP_DEFINES_VH
`define MQP_DEFINES_VH

// Register byte offsets
`define MQP_OFS_DATA   8'h00
`define MQP_OFS_STAT   8'h04
`define MQP_OFS_ISTAT  8'h08
`define MQP_OFS_IMASK  8'h0C
`define MQP_OFS_CFG    8'h10

// Status register fields
`define MQP_ST_OBF     0
`define MQP_ST_IBF     1
`define MQP_ST_CMD     3
`define MQP_ST_BTN_LO  4
`define MQP_ST_PWR     7

// Input port field positions
`define MQP_P1_XA      0
`define MQP_P1_XB      1
`define MQP_P1_YA      2
`define MQP_P1_YB      3
`define MQP_P1_BTN_LO  4
`define MQP_P1_PWR     7

// Event status bits, reset values
`define MQP_EV_BYTE    0
`define MQP_EV_BTN     1
`define MQP_EV_REJ     2
`define MQP_EV_W       3
`define MQP_IMASK_RST  3'h0
`define MQP_BTN_RST    3'h7
`define MQP_P1_RST     8'h70

// Packet headers and command headers
`define MQP_HDR_ALL    8'h41
`define MQP_HDR_MOT    8'h4D
`define MQP_HDR_BTN    8'h42
`define MQP_CMD_MOT    8'h08
`define MQP_CMD_BTN    8'h10
`define MQP_CMD_TIM    8'h20
`define MQP_CMD_LEN    3'h2
`define MQP_PKT_LEN    3'h5

// Accumulator limits
`define MQP_ACC_MAX    16'h7FDF
`define MQP_ACC_MIN    16'h8021

// Timer pacing, about 40 expiries per second
`define MQP_CLK_KHZ    125000
`define MQP_TICK_US    25000
`define MQP_TICK_CYC   (`MQP_TICK_US * (`MQP_CLK_KHZ / 1000))

`endif

// [core/mqp_axis.v]
// One motion axis: quadrature step decode and a saturating working accumulator.
// Assumes phase inputs are already synchronised and held stable while step_en is high.
`timescale 1ns/100ps
`include "mqp_defines.vh"
module mqp_axis #(
   parameter W = 16
) (
   // Clock and reset
   input  wire         clk,
   input  wire         rst_n,
   // Control
   input  wire         step_en,
   input  wire         clear,
   input  wire [1:0]   phase,
   // Result
   output reg  [W-1:0] acc_ff
);
   reg  [1:0] old_ff;
   reg  [1:0] nxt_diff;

   // Gray position to binary index: 00,01,11,10 -> 0,1,2,3
   function [1:0] gray_idx;
      input [1:0] g;
      begin
         gray_idx = {g[1], g[1] ^ g[0]};
      end
   endfunction

   // Index difference: 1 forward, 3 backward, 2 means two edges missed
   always @* begin
      nxt_diff = gray_idx(phase) - gray_idx(old_ff);
   end

   // Accumulate with saturation so a long burst never flips sign
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         old_ff <= 2'h0;
         acc_ff <= {W{1'b0}};
      end else if (clear) begin
         acc_ff <= {W{1'b0}};
      end else if (step_en) begin
         old_ff <= phase;
         if (nxt_diff == 2'h1 && acc_ff != `MQP_ACC_MAX) begin
            acc_ff <= acc_ff + 1'b1;
         end else if (nxt_diff == 2'h3 && acc_ff != `MQP_ACC_MIN) begin
            acc_ff <= acc_ff - 1'b1;
         end
      end
   end
endmodule // mqp_axis

// [core/mqp_timer.v]
// Pacing timer: counts down a fixed period and holds its expired flag until restarted.
// Assumes restart is a one-cycle pulse from the same clock domain.
`timescale 1ns/100ps
module mqp_timer #(
   parameter CYC = 32'd3125000
) (
   // Clock and reset
   input  wire clk,
   input  wire rst_n,
   // Control
   input  wire restart,
   output reg  expired_ff
);
   reg [31:0] cnt_ff;

   // Count down; expiry stays set so a late poll never misses it
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff     <= 32'h0;
         expired_ff <= 1'b0;
      end else if (restart) begin
         cnt_ff     <= CYC - 32'h1;
         expired_ff <= 1'b0;
      end else if (cnt_ff != 32'h0) begin
         cnt_ff <= cnt_ff - 32'h1;
      end else begin
         expired_ff <= 1'b1;
      end
   end
endmodule // mqp_timer

// [core/mqp_top.v]
// Mouse quadrature poll cycle: sampling loop, host data and status ports over AXI4-Lite.
// Assumes pin inputs (synchronised here); host line toggles per signal, irq is a masked level.
`timescale 1ns/100ps
`include "mqp_defines.vh"
module mqp_top #(
   parameter TICK_CYC = `MQP_TICK_CYC
) (
   // Clock and reset
   input  wire        ref_clk,
   input  wire        rstn,
   // Pins
   input  wire [7:0]  mouse_calendar_input_port,
   output reg         host_irq_line_ff,
   output reg         irq_ff,
   // AXI4-Lite write address
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);
   // Main cycle states
   localparam [3:0] ST_SNAP   = 4'h1;
   localparam [3:0] ST_DECODE = 4'h2;
   localparam [3:0] ST_EVENT  = 4'h4;
   localparam [3:0] ST_TIMER  = 4'h8;
   // Register selects
   localparam [5:0] SEL_DATA  = 6'h01;
   localparam [5:0] SEL_STAT  = 6'h02;
   localparam [5:0] SEL_ISTAT = 6'h04;
   localparam [5:0] SEL_IMASK = 6'h08;
   localparam [5:0] SEL_CFG   = 6'h10;
   localparam [5:0] SEL_NONE  = 6'h20;
   reg         rst_meta_ff;
   reg         rst_n_ff;
   reg  [7:0]  p1_meta_ff;
   reg  [7:0]  p1_sync_ff;
   reg  [7:0]  snap_ff;
   reg  [3:0]  state_ff;
   reg  [2:0]  btn_ff;
   reg         btn_pend_ff;
   reg         obf_ff;
   reg         ibf_ff;
   reg         cmd_flag_ff;
   reg  [7:0]  ibuf_ff [0:3];
   reg  [2:0]  icnt_ff;
   reg  [7:0]  obuf_ff [0:4];
   reg  [2:0]  olen_ff;
   reg  [2:0]  oidx_ff;
   reg  [7:0]  odata_ff;
   reg  [7:0]  mot_thr_ff;
   reg         btn_en_ff;
   reg         tim_en_ff;
   reg  [2:0]  istat_ff;
   reg  [2:0]  imask_ff;
   reg         aw_got_ff;
   reg         w_got_ff;
   reg  [7:0]  awaddr_ff;
   reg  [31:0] wdata_ff;
   reg  [3:0]  wstrb_ff;
   wire [15:0] acc_x;
   wire [15:0] acc_y;
   wire        tmr_exp;
   integer     i;
   // Address decode, shared by the read and write paths
   function [5:0] reg_sel;
      input [7:0] a;
      begin
         case (a)
            `MQP_OFS_DATA:  reg_sel = SEL_DATA;
            `MQP_OFS_STAT:  reg_sel = SEL_STAT;
            `MQP_OFS_ISTAT: reg_sel = SEL_ISTAT;
            `MQP_OFS_IMASK: reg_sel = SEL_IMASK;
            `MQP_OFS_CFG:   reg_sel = SEL_CFG;
            default:        reg_sel = SEL_NONE;
         endcase
      end
   endfunction
   // Magnitude of a signed accumulator
   function [15:0] mag;
      input [15:0] v;
      begin
         mag = v[15] ? (~v + 16'h1) : v;
      end
   endfunction
   // Reset release through two flops; assertion stays asynchronous
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff    <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff    <= rst_meta_ff;
      end
   end
   // Pin synchroniser; only the second stage is read
   always @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         p1_meta_ff <= `MQP_P1_RST; // Idle levels: no false button edge
         p1_sync_ff <= `MQP_P1_RST;
      end else begin
         p1_meta_ff <= mouse_calendar_input_port;
         p1_sync_ff <= p1_meta_ff;
      end
   end
   // Bus write taken once both address and data are held
   wire       wr_do   = aw_got_ff & w_got_ff & ~s_axi_bvalid;
   wire [5:0] wr_sel  = reg_sel(awaddr_ff);
   wire       wr_lo   = wr_do & wstrb_ff[0];
   wire       wr_host = wr_lo & (wr_sel == SEL_DATA || wr_sel == SEL_STAT);
   wire       ar_hs   = s_axi_arvalid & s_axi_arready;
   wire [5:0] rd_sel  = reg_sel(s_axi_araddr);
   wire       rd_data = ar_hs & (rd_sel == SEL_DATA);
   // Event triggers and output buffer state; state bits 1..3 are decode, event, timer
   wire       buf_more = (oidx_ff < olen_ff);
   wire       mot_hit  = (mot_thr_ff != 8'h00) &&
                         (mag(acc_x) >= {8'h00, mot_thr_ff} || mag(acc_y) >= {8'h00, mot_thr_ff});
   wire       evt_go   = state_ff[2] & ~buf_more & (mot_hit | (btn_en_ff & btn_pend_ff));
   wire       cmd_go   = state_ff[2] & ~evt_go & cmd_flag_ff & ~wr_host;
   wire       cmd_hdr  = (ibuf_ff[0] == `MQP_CMD_MOT) || (ibuf_ff[0] == `MQP_CMD_BTN) ||
                         (ibuf_ff[0] == `MQP_CMD_TIM);
   wire       cmd_ok   = cmd_hdr && (icnt_ff == `MQP_CMD_LEN);
   wire       tmr_act  = state_ff[3] & tmr_exp;
   wire       tim_go   = tmr_act & ~obf_ff & ~buf_more & tim_en_ff;
   wire       acc_clr  = evt_go | tim_go;
   wire       btn_chg  = state_ff[1] & (snap_ff[`MQP_P1_BTN_LO+2:`MQP_P1_BTN_LO] != btn_ff);
   wire       sig_host = tmr_act & (obf_ff | buf_more | tim_en_ff);
   wire [7:0] pk_hdr   = tim_go ? `MQP_HDR_ALL : (mot_hit ? `MQP_HDR_MOT : `MQP_HDR_BTN);
   // Sticky events: a set in the clearing cycle survives
   wire [2:0] ev_set  = {cmd_go & ~cmd_ok, btn_chg, sig_host};
   wire [2:0] ev_w1c  = (wr_lo && wr_sel == SEL_ISTAT) ? wdata_ff[2:0] : 3'h0;
   wire [2:0] nxt_ist = (istat_ff & ~ev_w1c) | ev_set;
   // Both axes share one decoder design
   mqp_axis #(.W(16)) u_axis_x (
      .clk     (ref_clk),
      .rst_n   (rst_n_ff),
      .step_en (state_ff[1]),
      .clear   (acc_clr),
      .phase   ({snap_ff[`MQP_P1_XB], snap_ff[`MQP_P1_XA]}),
      .acc_ff  (acc_x)
   );
   mqp_axis #(.W(16)) u_axis_y (
      .clk     (ref_clk),
      .rst_n   (rst_n_ff),
      .step_en (state_ff[1]),
      .clear   (acc_clr),
      .phase   ({snap_ff[`MQP_P1_YB], snap_ff[`MQP_P1_YA]}),
      .acc_ff  (acc_y)
   );
   mqp_timer #(.CYC(TICK_CYC)) u_timer (
      .clk        (ref_clk),
      .rst_n      (rst_n_ff),
      .restart    (tmr_act),
      .expired_ff (tmr_exp)
   );
   // Main cycle, host ports and event registers
   always @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         state_ff         <= ST_SNAP;
         snap_ff          <= 8'h00;
         btn_ff           <= `MQP_BTN_RST;
         btn_pend_ff      <= 1'b0;
         obf_ff           <= 1'b0;
         ibf_ff           <= 1'b0;
         cmd_flag_ff      <= 1'b0;
         icnt_ff          <= 3'h0;
         olen_ff          <= 3'h0;
         oidx_ff          <= 3'h0;
         odata_ff         <= 8'h00;
         mot_thr_ff       <= 8'h00;
         btn_en_ff        <= 1'b0;
         tim_en_ff        <= 1'b0;
         istat_ff         <= 3'h0;
         imask_ff         <= `MQP_IMASK_RST;
         irq_ff           <= 1'b0;
         host_irq_line_ff <= 1'b0;
         for (i = 0; i < 4; i = i + 1) begin
            ibuf_ff[i] <= 8'h00;
            obuf_ff[i] <= 8'h00;
         end
         obuf_ff[4] <= 8'h00;
      end else begin
         // Loop order: snapshot, decode, event or command, timer
         case (state_ff)
            ST_SNAP:   state_ff <= ST_DECODE;
            ST_DECODE: state_ff <= ST_EVENT;
            ST_EVENT:  state_ff <= ST_TIMER;
            ST_TIMER:  state_ff <= ST_SNAP;
            default:   state_ff <= ST_SNAP;
         endcase
         if (state_ff[0]) begin
            snap_ff <= p1_sync_ff;
         end
         if (btn_chg) begin
            btn_ff      <= snap_ff[`MQP_P1_BTN_LO+2:`MQP_P1_BTN_LO];
            btn_pend_ff <= 1'b1;
         end
         // Host byte into the input buffer; extra bytes beyond four are dropped
         if (wr_host) begin
            if (icnt_ff < 3'h4) begin
               ibuf_ff[icnt_ff[1:0]] <= wdata_ff[7:0];
               icnt_ff               <= icnt_ff + 3'h1;
            end
            ibf_ff <= 1'b1;
            if (wr_sel == SEL_STAT) begin
               cmd_flag_ff <= 1'b1;
            end
         end else if (state_ff[0]) begin
            ibf_ff <= 1'b0;
         end
         // Command dispatch; a bad header or length flushes the buffer and raises the reject event
         if (cmd_go) begin
            if (cmd_ok) begin
               case (ibuf_ff[0])
                  `MQP_CMD_MOT: mot_thr_ff <= ibuf_ff[1];
                  `MQP_CMD_BTN: btn_en_ff  <= (ibuf_ff[1] != 8'h00);
                  `MQP_CMD_TIM: tim_en_ff  <= (ibuf_ff[1] != 8'h00);
                  default:      tim_en_ff  <= tim_en_ff;
               endcase
            end
            icnt_ff     <= 3'h0;
            cmd_flag_ff <= 1'b0;
         end
         // Pack accumulators behind a header
         if (acc_clr) begin
            obuf_ff[0] <= pk_hdr;
            obuf_ff[1] <= acc_x[15:8];
            obuf_ff[2] <= acc_x[7:0];
            obuf_ff[3] <= acc_y[15:8];
            obuf_ff[4] <= acc_y[7:0];
            olen_ff    <= `MQP_PKT_LEN;
            oidx_ff    <= 3'h0;
            if (evt_go) begin
               btn_pend_ff <= 1'b0;
            end
         end
         // Host read of the data port takes the byte; a load in the same cycle wins
         if (rd_data) begin
            obf_ff <= 1'b0;
         end
         if (tmr_act && !obf_ff && buf_more) begin
            odata_ff <= obuf_ff[oidx_ff];
            oidx_ff  <= oidx_ff + 3'h1;
            obf_ff   <= 1'b1;
         end else if (tim_go) begin
            odata_ff <= `MQP_HDR_ALL;
            oidx_ff  <= 3'h1;
            olen_ff  <= `MQP_PKT_LEN;
            obf_ff   <= 1'b1;
         end
         if (sig_host) begin
            host_irq_line_ff <= ~host_irq_line_ff;
         end
         // Interrupt status, mask and level output
         istat_ff <= nxt_ist;
         if (wr_lo && wr_sel == SEL_IMASK) begin
            imask_ff <= wdata_ff[2:0];
            irq_ff   <= |(nxt_ist & wdata_ff[2:0]);
         end else begin
            irq_ff   <= |(nxt_ist & imask_ff);
         end
      end
   end
   // AXI write channel: address and data accepted in either order, one at a time
   always @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         aw_got_ff     <= 1'b0;
         w_got_ff      <= 1'b0;
         awaddr_ff     <= 8'h00;
         wdata_ff      <= 32'h0000_0000;
         wstrb_ff      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff     <= 1'b1;
            awaddr_ff     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (!aw_got_ff && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff     <= 1'b1;
            wdata_ff     <= s_axi_wdata;
            wstrb_ff     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (!w_got_ff && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
         if (wr_do) begin
            aw_got_ff    <= 1'b0;
            w_got_ff     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_sel == SEL_NONE || wr_sel == SEL_CFG) ? 2'h2 : 2'h0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // AXI read channel: data captured at the address handshake
   always @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
      end else if (ar_hs) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= (rd_sel == SEL_NONE) ? 2'h2 : 2'h0;
         case (rd_sel)
            SEL_DATA:  s_axi_rdata <= {24'h000000, odata_ff};
            SEL_STAT:  s_axi_rdata <= {24'h000000, snap_ff[`MQP_P1_PWR], btn_ff, cmd_flag_ff,
                                       1'b0, ibf_ff, obf_ff};
            SEL_ISTAT: s_axi_rdata <= {29'h0, istat_ff};
            SEL_IMASK: s_axi_rdata <= {29'h0, imask_ff};
            SEL_CFG:   s_axi_rdata <= {22'h0, tim_en_ff, btn_en_ff, mot_thr_ff};
            default:   s_axi_rdata <= 32'h0000_0000;
         endcase
      end else if (!s_axi_rvalid || s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule // mqp_top

// [dv/mqp_monitor.sv]
// Checker for mqp_top: bus handshakes, reset, host line pacing.
// Assumes a bind into mqp_top; sees only its ports.
`timescale 1ns/100ps
module mqp_monitor #(
   parameter TICK_CYC = 32
) (
   // Clock and reset
   input wire        ref_clk,
   input wire        rstn,
   // Host line
   input wire        host_irq_line_ff,
   // Bus handshakes
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   int gap_ff;
   // Cycles since the host line last moved
   always @(posedge ref_clk or negedge rstn)
      if (!rstn)
         gap_ff <= 0;
      else if ($changed(host_irq_line_ff))
         gap_ff <= 0;
      else
         gap_ff <= gap_ff + 1;
   // Write and read address handshakes
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   wr_answer_a: assert property (wr_taken |-> ##[2:3] s_axi_bvalid)
      else $error("write response missing");
   rd_answer_a: assert property (rd_taken |-> ##[1:2] s_axi_rvalid)
      else $error("read response missing");
   wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answering");
   rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answering");
   bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response changed");
   slverr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
      else $error("error read with data");
   host_pace_a: assert property ($changed(host_irq_line_ff) |-> gap_ff >= TICK_CYC / 2)
      else $error("host line toggled too soon");
   reset_quiet_a: assert property ($rose(rstn) |-> (!s_axi_bvalid && !s_axi_rvalid && !host_irq_line_ff) [*2])
      else $error("outputs busy after reset");
endmodule // mqp_monitor

// [dv/mqp_host_model.sv]
// Host model: bus master with a write and a read task.
// Assumes one caller at a time; the bench timeout bounds waits.
`timescale 1ns/100ps
module mqp_host_model (
   // Clock
   input  wire         clk,
   // Write address and data
   output logic [7:0]  awaddr = 8'h00,
   output logic        awvalid = 1'b0,
   input  wire         awready,
   output logic [31:0] wdata = 32'h0,
   output logic [3:0]  wstrb = 4'h0,
   output logic        wvalid = 1'b0,
   input  wire         wready,
   // Write response
   input  wire  [1:0]  bresp,
   input  wire         bvalid,
   output logic        bready = 1'b0,
   // Read
   output logic [7:0]  araddr = 8'h00,
   output logic        arvalid = 1'b0,
   input  wire         arready,
   input  wire  [31:0] rdata,
   input  wire  [1:0]  rresp,
   input  wire         rvalid,
   output logic        rready = 1'b0
);
   // Offers address and data together, releases each as it is taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit aw_done = 1'b0;
      bit w_done = 1'b0;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge clk);
         if (!aw_done && awready) begin
            awvalid <= 1'b0;
            aw_done = 1'b1;
         end
         if (!w_done && wready) begin
            wvalid <= 1'b0;
            w_done = 1'b1;
         end
      end
      bready <= 1'b1;
      do @(posedge clk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask
   // Read cycle; rready stays up until the answer is sampled
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge clk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule // mqp_host_model

// [dv/mqp_top_tb_top.sv]
// Bench top for mqp_top: host model on the bus, pins driven here.
// Assumes a short pacing period.
`timescale 1ns/100ps
`include "mqp_defines.vh"
module mqp_top_tb_top;
   localparam int TICK = 32;
   logic        ref_clk = 1'b0;
   logic        rstn = 1'b0;
   logic [7:0]  pins = 8'h70;
   logic [31:0] rd;
   logic [1:0]  rsp;
   int          n_mismatch = 0;
   int          samples_checked = 0;
   wire [7:0]   awaddr, araddr;
   wire [31:0]  wdata, rdata;
   wire [3:0]   wstrb;
   wire [1:0]   bresp, rresp;
   wire         awvalid, awready, wvalid, wready, bvalid, bready;
   wire         arvalid, arready, rvalid, rready, host_line, irq;
   mqp_top #(.TICK_CYC(TICK)) uut (
      .ref_clk(ref_clk), .rstn(rstn), .mouse_calendar_input_port(pins), .host_irq_line_ff(host_line),
      .irq_ff(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   mqp_host_model host (
      .clk(ref_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));
   // Clock at 125 MHz
   initial forever #4 ref_clk = ~ref_clk;
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      host.rd(a, rd, rsp);
      chk(rd, exp);
   endtask
   task automatic wr_rsp(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
      host.wr(a, d, rsp);
      chk({30'h0, rsp}, {30'h0, exp});
   endtask
   // Command: header to data port, value to status port
   task automatic cmd(input logic [7:0] hdr, input logic [7:0] val);
      wr_rsp(`MQP_OFS_DATA, {24'h0, hdr}, 2'h0);
      wr_rsp(`MQP_OFS_STAT, {24'h0, val}, 2'h0);
      repeat (12) @(posedge ref_clk);
   endtask
   // Each phase held past one sampling loop
   task automatic set_ph(input logic [1:0] x, input logic [1:0] y);
      pins[3:0] <= {y, x};
      repeat (8) @(posedge ref_clk);
   endtask
   // Poll the full flag, optionally see a repeat, take one byte
   task automatic get_byte(input logic [7:0] exp, input bit rep);
      int n = 0;
      logic lv;
      for (int i = 0; i < 80; i++) begin
         host.rd(`MQP_OFS_STAT, rd, rsp);
         if (rd[0] === 1'b1)
            break;
      end
      if (rep) begin
         lv = host_line;
         repeat (TICK + 4) begin
            @(posedge ref_clk);
            if (host_line !== lv)
               n++;
            lv = host_line;
         end
         chk({31'h0, n > 0}, 32'h1);
      end
      host.rd(`MQP_OFS_DATA, rd, rsp);
      chk({24'h0, rd[7:0]}, {24'h0, exp});
      host.rd(`MQP_OFS_STAT, rd, rsp);
      if (!rep)
         chk({31'h0, rd[0]}, 32'h0);
   endtask
   task automatic pkt(input logic [7:0] hdr, input logic [15:0] x, input logic [15:0] y);
      logic [39:0] b;
      b = {hdr, x, y};
      get_byte(b[39:32], 1'b1);
      for (int i = 1; i < 5; i++)
         get_byte(b[39-8*i -: 8], 1'b0);
   endtask
   task automatic t_reset;
      rd_chk(`MQP_OFS_STAT, 32'h70);
      rd_chk(`MQP_OFS_ISTAT, 32'h0);
      rd_chk(`MQP_OFS_IMASK, 32'h0);
      rd_chk(`MQP_OFS_CFG, 32'h0);
      chk({30'h0, host_line, irq}, 32'h0);
      wr_rsp(`MQP_OFS_CFG, 32'h1, 2'h2);
      rd_chk(8'h20, 32'h0);
      chk({30'h0, rsp}, 32'h2);
      $display("test reset done");
   endtask
   task automatic t_button;
      pins[5] <= 1'b0;
      repeat (12) @(posedge ref_clk);
      rd_chk(`MQP_OFS_STAT, 32'h50);
      rd_chk(`MQP_OFS_ISTAT, 32'h2);
      chk({31'h0, irq}, 32'h0);
      wr_rsp(`MQP_OFS_IMASK, 32'h2, 2'h0);
      repeat (3) @(posedge ref_clk);
      chk({31'h0, irq}, 32'h1);
      pins[5] <= 1'b1;
      repeat (12) @(posedge ref_clk);
      wr_rsp(`MQP_OFS_ISTAT, 32'h2, 2'h0);
      repeat (3) @(posedge ref_clk);
      chk({31'h0, irq}, 32'h0);
      rd_chk(`MQP_OFS_STAT, 32'h70);
      $display("test button done");
   endtask
   task automatic t_reject;
      cmd(8'h01, 8'h00);
      rd_chk(`MQP_OFS_ISTAT, 32'h4);
      wr_rsp(`MQP_OFS_ISTAT, 32'h4, 2'h0);
      wr_rsp(`MQP_OFS_STAT, {24'h0, `MQP_CMD_MOT}, 2'h0);
      repeat (12) @(posedge ref_clk);
      rd_chk(`MQP_OFS_ISTAT, 32'h4);
      rd_chk(`MQP_OFS_STAT, 32'h70);
      rd_chk(`MQP_OFS_CFG, 32'h0);
      wr_rsp(`MQP_OFS_ISTAT, 32'h4, 2'h0);
      $display("test reject done");
   endtask
   // Y -2, X null, X +3; threshold 3 fires on X
   task automatic t_motion;
      cmd(`MQP_CMD_MOT, 8'h03);
      rd_chk(`MQP_OFS_CFG, 32'h3);
      set_ph(2'h0, 2'h2);
      set_ph(2'h0, 2'h3);
      set_ph(2'h3, 2'h3);
      set_ph(2'h2, 2'h3);
      set_ph(2'h0, 2'h3);
      set_ph(2'h1, 2'h3);
      pkt(`MQP_HDR_MOT, 16'h0003, 16'hFFFE);
      rd_chk(`MQP_OFS_ISTAT, 32'h1);
      wr_rsp(`MQP_OFS_ISTAT, 32'h1, 2'h0);
      cmd(`MQP_CMD_MOT, 8'h00);
      $display("test motion done");
   endtask
   task automatic t_timed;
      set_ph(2'h3, 2'h3);
      cmd(`MQP_CMD_TIM, 8'h01);
      rd_chk(`MQP_OFS_CFG, 32'h200);
      pkt(`MQP_HDR_ALL, 16'h0001, 16'h0000);
      pkt(`MQP_HDR_ALL, 16'h0000, 16'h0000);
      $display("test timed done");
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (10) @(posedge ref_clk);
      t_reset;
      t_button;
      t_reject;
      t_motion;
      t_timed;
      finish_test;
   end
   // Tests take about a thousand cycles; wide margin
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      finish_test;
   end
endmodule // mqp_top_tb_top
bind mqp_top mqp_monitor #(.TICK_CYC(TICK_CYC)) mon (
   .ref_clk(ref_clk), .rstn(rstn), .host_irq_line_ff(host_irq_line_ff), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
